// file: adc_input_mux_select.sv
// input-select registers and mux select generation for converter channel 0
// Contract
// - Sample B negative select bit 31 picks low reference when 0 and analog input 1 when 1.
// - Bits 27 to 24 hold the Sample B positive select in the shared positive code.
// - Sample A negative select bit 23 picks low reference when 0 and analog input 1 when 1.
// - Bits 19 to 16 hold the Sample A positive select in the shared positive code.
// - Positive codes 0 to 12 select the analog input of that number.
// - Code 13 picks the temperature sensor, 14 the internal reference, 15 leaves it open.
// - Bits 30-28, 22-20 and 15-0 of the input-select register read zero, ignore writes.
// - The scan register has 16 read/write mask bits cleared at reset; bits 31-16 read zero.
// - Without alternation every sample uses A; with it the first uses A, then B and A alternate.
// - A set mask bit includes its input in the scan; bits 13, 14, 15 pick unit, reference, ground.
// - Scanning takes inputs from the mask, and calibration ties both inputs to low reference.
//
// Local design decisions: the strobed register port and the register addresses.
module adc_input_mux_select (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic      [31:0] rdata,
  input  wire logic        sample_start,
  output logic      [17:0] pos_lines,
  output logic             neg_analog_1,
  output logic             neg_low_ref,
  output logic             sample_is_b
);
  // software-visible storage
  logic [31:0]               input_select_reg;
  logic [31:0]               input_select_next;
  logic [15:0]               scan_input_mask_reg;
  logic [15:0]               scan_input_mask_next;
  logic [2:0]                control_reg;
  logic [2:0]                control_next;

  // read answer, one cycle per strobe
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;

  // sequence position: A/B phase and scan pointer
  adc_mux_pkg::phase_t       phase_reg;
  adc_mux_pkg::phase_t       phase_next;
  logic [3:0]                scan_last_reg;
  logic [3:0]                scan_last_next;
  logic                      scan_restart_reg;
  logic                      scan_restart_next;

  // selection and status captured at the last sample start
  logic [17:0]               pos_lines_reg;
  logic [17:0]               pos_lines_next;
  logic                      neg_an1_reg;
  logic                      neg_an1_next;
  logic                      neg_low_reg;
  logic                      neg_low_next;
  logic                      cur_b_reg;
  logic                      cur_b_next;
  logic                      cur_scan_reg;
  logic                      cur_scan_next;
  logic [3:0]                cur_idx_reg;
  logic [3:0]                cur_idx_next;
  logic                      cur_cal_reg;
  logic                      cur_cal_next;

  // field views and the source chosen for this sample
  logic                      alternate_sample_enable;
  logic                      input_scan_enable;
  logic                      offset_calibration_enable;
  logic                      use_b;
  logic [3:0]                pos_select_sample_a;
  logic [3:0]                pos_select_sample_b;
  logic                      neg_select_sample_a;
  logic                      neg_select_sample_b;
  logic [3:0]                sel_pos_code;
  logic                      sel_neg_code;

  // submodule nets
  logic [3:0]                scan_idx;
  logic                      scan_found;
  logic [17:0]               dec_pos_lines;
  logic                      dec_neg_an1;
  logic                      dec_neg_low;
  logic                      ctrl_write;

  // field views of the stored registers
  assign pos_select_sample_b       = input_select_reg[adc_mux_pkg::POS_B_LSB +: 4];
  assign pos_select_sample_a       = input_select_reg[adc_mux_pkg::POS_A_LSB +: 4];
  assign neg_select_sample_b       = input_select_reg[adc_mux_pkg::NEG_B_BIT];
  assign neg_select_sample_a       = input_select_reg[adc_mux_pkg::NEG_A_BIT];
  assign alternate_sample_enable   = control_reg[adc_mux_pkg::CTRL_ALT_BIT];
  assign input_scan_enable         = control_reg[adc_mux_pkg::CTRL_SCAN_BIT];
  assign offset_calibration_enable = control_reg[adc_mux_pkg::CTRL_CAL_BIT];
  assign ctrl_write = wr_strobe && (addr == adc_mux_pkg::OFF_CONTROL);

  // B settings only when alternating and on the odd sample
  assign use_b = alternate_sample_enable && (phase_reg == adc_mux_pkg::PHASE_B);

  // A or B fields feed the decoder; the B pair is only used on a B phase
  always_comb begin
    if (use_b) begin
      sel_pos_code = pos_select_sample_b;
      sel_neg_code = neg_select_sample_b;
    end else begin
      sel_pos_code = pos_select_sample_a;
      sel_neg_code = neg_select_sample_a;
    end
  end

  adc_scan_pick u_scan_pick (
    .mask     (scan_input_mask_reg),
    .last_idx (scan_last_reg),
    .restart  (scan_restart_reg),
    .next_idx (scan_idx),
    .found    (scan_found),
    .wrapped  ()
  );

  adc_mux_decode u_mux_decode (
    .calibrate    (offset_calibration_enable),
    .scanning     (input_scan_enable),
    .scan_found   (scan_found),
    .scan_idx     (scan_idx),
    .pos_code     (sel_pos_code),
    .neg_code     (sel_neg_code),
    .pos_lines    (dec_pos_lines),
    .neg_analog_1 (dec_neg_an1),
    .neg_low_ref  (dec_neg_low)
  );

  // register writes; unimplemented bits are masked off before storage
  always_comb begin
    input_select_next    = input_select_reg;
    scan_input_mask_next = scan_input_mask_reg;
    control_next         = control_reg;
    if (wr_strobe) begin
      unique case (addr)
        adc_mux_pkg::OFF_INPUT_SELECT: begin
          input_select_next = wdata & adc_mux_pkg::INPUT_SELECT_WMASK;
        end
        adc_mux_pkg::OFF_SCAN_SELECT: begin
          scan_input_mask_next = wdata[15:0];
        end
        adc_mux_pkg::OFF_CONTROL: begin
          control_next = wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_strobe) begin
      unique case (addr)
        adc_mux_pkg::OFF_INPUT_SELECT: begin
          rdata_next = input_select_reg; // reserved bits stored as zero
        end
        adc_mux_pkg::OFF_SCAN_SELECT: begin
          rdata_next = {16'h0000, scan_input_mask_reg};
        end
        adc_mux_pkg::OFF_CONTROL: begin
          rdata_next = {29'h0000_0000, control_reg};
        end
        adc_mux_pkg::OFF_STATUS: begin
          rdata_next[adc_mux_pkg::STAT_B_BIT]          = cur_b_reg;
          rdata_next[adc_mux_pkg::STAT_SCANNED_BIT]    = cur_scan_reg;
          rdata_next[adc_mux_pkg::STAT_CAL_BIT]        = cur_cal_reg;
          rdata_next[adc_mux_pkg::STAT_IDX_LSB +: 4]   = cur_idx_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000; // unmapped reads answer zero
        end
      endcase
    end
  end

  // capture the decoded selection at each sample start
  always_comb begin
    pos_lines_next = pos_lines_reg;
    neg_an1_next   = neg_an1_reg;
    neg_low_next   = neg_low_reg;
    cur_b_next     = cur_b_reg;
    if (sample_start) begin
      pos_lines_next = dec_pos_lines;
      neg_an1_next   = dec_neg_an1;
      neg_low_next   = dec_neg_low;
      cur_b_next     = use_b && !input_scan_enable && !offset_calibration_enable;
    end
  end

  // status of the last sample; calibration is a flag of its own, since an empty
  // scan lands on the low reference lines as well
  always_comb begin
    cur_scan_next = cur_scan_reg;
    cur_cal_next  = cur_cal_reg;
    cur_idx_next  = cur_idx_reg;
    if (sample_start) begin
      cur_scan_next = input_scan_enable && !offset_calibration_enable;
      cur_cal_next  = offset_calibration_enable;
      cur_idx_next  = scan_idx;
    end
  end

  // sequence position: phase steps on each sample start, the scan pointer only on a scanned start with a set mask bit
  always_comb begin
    phase_next        = phase_reg;
    scan_last_next    = scan_last_reg;
    scan_restart_next = scan_restart_reg;
    if (sample_start) begin
      // alternate after each sample; stays on A when alternation is off
      if (alternate_sample_enable && phase_reg == adc_mux_pkg::PHASE_A) begin
        phase_next = adc_mux_pkg::PHASE_B;
      end else begin
        phase_next = adc_mux_pkg::PHASE_A;
      end
      // step the scan pointer only over included inputs
      if (input_scan_enable && scan_found) begin
        scan_last_next    = scan_idx;
        scan_restart_next = 1'b0;
      end
    end
    // a control write starts a fresh sequence, so the next sample is A again
    if (ctrl_write) begin
      phase_next        = adc_mux_pkg::PHASE_A;
      scan_restart_next = 1'b1;
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      input_select_reg    <= adc_mux_pkg::INPUT_SELECT_RESET;
      scan_input_mask_reg <= adc_mux_pkg::SCAN_SELECT_RESET;
      control_reg         <= adc_mux_pkg::CTRL_RESET;
    end else begin
      input_select_reg    <= input_select_next;
      scan_input_mask_reg <= scan_input_mask_next;
      control_reg         <= control_next;
    end
  end

  // read answer; idles at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sequence position; reset starts on A with a fresh scan
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg        <= adc_mux_pkg::PHASE_A;
      scan_last_reg    <= 4'h0;
      scan_restart_reg <= 1'b1;
    end else begin
      phase_reg        <= phase_next;
      scan_last_reg    <= scan_last_next;
      scan_restart_reg <= scan_restart_next;
    end
  end

  // captured selection; reset shows analog input 0 against the low reference
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_lines_reg <= adc_mux_pkg::POS_LINES_RESET;
      neg_an1_reg   <= 1'b0;
      neg_low_reg   <= 1'b1;
      cur_b_reg     <= 1'b0;
    end else begin
      pos_lines_reg <= pos_lines_next;
      neg_an1_reg   <= neg_an1_next;
      neg_low_reg   <= neg_low_next;
      cur_b_reg     <= cur_b_next;
    end
  end

  // last-sample status
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_scan_reg <= 1'b0;
      cur_cal_reg  <= 1'b0;
      cur_idx_reg  <= 4'h0;
    end else begin
      cur_scan_reg <= cur_scan_next;
      cur_cal_reg  <= cur_cal_next;
      cur_idx_reg  <= cur_idx_next;
    end
  end

  // outputs come straight from flops
  assign rdata        = rdata_reg;
  assign pos_lines    = pos_lines_reg;
  assign neg_analog_1 = neg_an1_reg;
  assign neg_low_ref  = neg_low_reg;
  assign sample_is_b  = cur_b_reg;
endmodule : adc_input_mux_select

// file: adc_mux_chk.sv
// port-level checker for the channel 0 input-select block
module adc_mux_chk (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  input  wire logic [31:0] rdata,
  input  wire logic        sample_start,
  input  wire logic [17:0] pos_lines,
  input  wire logic        neg_analog_1,
  input  wire logic        neg_low_ref,
  input  wire logic        sample_is_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // read data stands only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(rd_strobe) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_input_res_zero: assert property ($past(rd_strobe) && $past(addr) == adc_mux_pkg::OFF_INPUT_SELECT
    |-> (rdata & ~adc_mux_pkg::INPUT_SELECT_WMASK) == 32'h0000_0000)
    else $error("reserved input-select bits read non-zero");
  a_scan_upper_zero: assert property ($past(rd_strobe) && $past(addr) == adc_mux_pkg::OFF_SCAN_SELECT
    |-> rdata[31:16] == 16'h0000)
    else $error("scan register upper half read non-zero");
  // at most one positive line, exactly one negative source
  a_pos_onehot: assert property ($onehot0(pos_lines))
    else $error("more than one positive line active");
  a_neg_exclusive: assert property (neg_analog_1 != neg_low_ref)
    else $error("negative select not exactly one source");
  // selection only moves on a taken sample start, so writes hit the next sample
  a_hold_no_start: assert property (!$past(sample_start) && !$past(rst) |-> $stable(pos_lines)
    && $stable(sample_is_b))
    else $error("selection changed without a sample start");
  a_b_then_a: assert property (sample_start && sample_is_b |=> !sample_is_b)
    else $error("two B samples in a row");
  a_b_not_lowref: assert property (sample_is_b |-> !pos_lines[adc_mux_pkg::LINE_LOW_REF])
    else $error("B sample on the low reference line");
  a_reset_state: assert property ($past(rst) |-> pos_lines == adc_mux_pkg::POS_LINES_RESET
    && neg_low_ref && !sample_is_b)
    else $error("outputs not at reset selection");

  c_b_sample: cover property (sample_start ##1 sample_is_b);
  c_ground: cover property (pos_lines[adc_mux_pkg::LINE_GROUND]);
  c_open: cover property (pos_lines == 18'h0_0000);
endmodule : adc_mux_chk

bind adc_input_mux_select adc_mux_chk u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rdata(rdata), .sample_start(sample_start), .pos_lines(pos_lines),
  .neg_analog_1(neg_analog_1), .neg_low_ref(neg_low_ref), .sample_is_b(sample_is_b)
);

// file: adc_mux_decode.sv
// turns a chosen input into one-hot positive lines and the negative select pair
module adc_mux_decode (
  input  wire logic        calibrate,
  input  wire logic        scanning,
  input  wire logic        scan_found,
  input  wire logic [3:0]  scan_idx,
  input  wire logic [3:0]  pos_code,
  input  wire logic        neg_code,
  output logic      [17:0] pos_lines,
  output logic             neg_analog_1,
  output logic             neg_low_ref
);
  // positive side
  always_comb begin
    pos_lines = '0;
    if (calibrate) begin
      pos_lines[adc_mux_pkg::LINE_LOW_REF] = 1'b1;
    end else if (scanning) begin
      if (!scan_found) begin
        pos_lines[adc_mux_pkg::LINE_LOW_REF] = 1'b1; // empty mask: convert low ref
      end else if (scan_idx <= adc_mux_pkg::CODE_LAST_ANALOG) begin
        pos_lines[scan_idx] = 1'b1;
      end else if (scan_idx == 4'(adc_mux_pkg::SCAN_CTU_BIT)) begin
        pos_lines[adc_mux_pkg::LINE_CHARGE_UNIT] = 1'b1;
      end else if (scan_idx == 4'(adc_mux_pkg::SCAN_INTERNAL_VOLTAGE_REFERENCE_BIT)) begin
        pos_lines[adc_mux_pkg::LINE_INTERNAL_VOLTAGE_REFERENCE] = 1'b1;
      end else begin
        pos_lines[adc_mux_pkg::LINE_GROUND] = 1'b1;
      end
    end else if (pos_code <= adc_mux_pkg::CODE_LAST_ANALOG) begin
      pos_lines[pos_code] = 1'b1;
    end else if (pos_code == adc_mux_pkg::CODE_TEMPERATURE) begin
      pos_lines[adc_mux_pkg::LINE_TEMPERATURE] = 1'b1;
    end else if (pos_code == adc_mux_pkg::CODE_INTERNAL_VOLTAGE_REFERENCE) begin
      pos_lines[adc_mux_pkg::LINE_INTERNAL_VOLTAGE_REFERENCE] = 1'b1;
    end
    // open code leaves every line low
  end

  // negative side; calibration ties it to low ref as well
  always_comb begin
    neg_analog_1 = !calibrate && neg_code;
    neg_low_ref  = calibrate || !neg_code;
  end
endmodule : adc_mux_decode

// file: adc_mux_pkg.sv
// constants shared by the input-select block: offsets, fields, codes and line indices
package adc_mux_pkg;
  // register bus
  localparam int unsigned ADDR_W             = 8;
  localparam int unsigned DATA_W             = 32;
  localparam logic [7:0]  OFF_INPUT_SELECT   = 8'h00;
  localparam logic [7:0]  OFF_SCAN_SELECT    = 8'h04;
  localparam logic [7:0]  OFF_CONTROL        = 8'h08;
  localparam logic [7:0]  OFF_STATUS         = 8'h0C;

  // input-select fields
  localparam int unsigned SEL_W              = 4;
  localparam int unsigned NEG_B_BIT          = 31;
  localparam int unsigned POS_B_LSB          = 24;
  localparam int unsigned NEG_A_BIT          = 23;
  localparam int unsigned POS_A_LSB          = 16;
  localparam logic [31:0] INPUT_SELECT_WMASK = 32'h8F8F_0000;
  localparam logic [31:0] INPUT_SELECT_RESET = 32'h0000_0000;

  // scan-select fields
  localparam int unsigned SCAN_W             = 16;
  localparam logic [15:0] SCAN_SELECT_RESET  = 16'h0000;
  localparam int unsigned SCAN_CTU_BIT       = 13;
  localparam int unsigned SCAN_INTERNAL_VOLTAGE_REFERENCE_BIT     = 14;
  localparam int unsigned SCAN_GROUND_BIT    = 15;

  // control fields
  localparam int unsigned CTRL_W             = 3;
  localparam int unsigned CTRL_ALT_BIT       = 0;
  localparam int unsigned CTRL_SCAN_BIT      = 1;
  localparam int unsigned CTRL_CAL_BIT       = 2;
  localparam logic [2:0]  CTRL_RESET         = 3'h0;

  // status fields
  localparam int unsigned STAT_B_BIT         = 0;
  localparam int unsigned STAT_SCANNED_BIT   = 1;
  localparam int unsigned STAT_CAL_BIT       = 2;
  localparam int unsigned STAT_IDX_LSB       = 4;

  // positive-input codes
  localparam logic [3:0]  CODE_LAST_ANALOG   = 4'hC;
  localparam logic [3:0]  CODE_TEMPERATURE   = 4'hD;
  localparam logic [3:0]  CODE_INTERNAL_VOLTAGE_REFERENCE         = 4'hE;
  localparam logic [3:0]  CODE_OPEN          = 4'hF;

  // positive mux select lines, one-hot; lines 0..12 are the analog inputs
  localparam int unsigned POS_LINES          = 18;
  localparam int unsigned LINE_TEMPERATURE   = 13;
  localparam int unsigned LINE_CHARGE_UNIT   = 14;
  localparam int unsigned LINE_INTERNAL_VOLTAGE_REFERENCE         = 15;
  localparam int unsigned LINE_GROUND        = 16;
  localparam int unsigned LINE_LOW_REF       = 17;
  localparam logic [17:0] POS_LINES_RESET    = 18'h0_0001;

  typedef enum logic {PHASE_A, PHASE_B} phase_t;
endpackage : adc_mux_pkg

// file: adc_scan_pick.sv
// finds the next set mask bit above the last scanned input, wrapping to the lowest
module adc_scan_pick (
  input  wire logic [15:0] mask,
  input  wire logic [3:0]  last_idx,
  input  wire logic        restart,
  output logic      [3:0]  next_idx,
  output logic             found,
  output logic             wrapped
);
  logic [15:0] above;

  // per bit: candidate if set and beyond the last one taken
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_above
      assign above[i] = mask[i] & (restart | (4'(i) > last_idx));
    end
  endgenerate

  // lowest candidate wins; with none above, wrap to the lowest set bit
  always_comb begin
    next_idx = 4'h0;
    found    = |mask;
    wrapped  = (above == 16'h0000);
    for (int k = 15; k >= 0; k--) begin
      if (wrapped ? mask[k] : above[k]) begin
        next_idx = 4'(k);
      end
    end
  end
endmodule : adc_scan_pick

// file: adc_seq_model.sv
// conversion sequencer stand-in: issues one-cycle sample start pulses
module adc_seq_model (
  input  wire logic clk,
  output logic      sample_start
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sample_start = 1'b0;
  // one pulse per sample; returns once the taking edge has landed
  task pulse();
    @(posedge clk);
    sample_start <= 1'b1;
    @(posedge clk);
    sample_start <= 1'b0;
    #1;
  endtask : pulse
endmodule : adc_seq_model

// file: test_adc_input_mux_select.sv
// self-checking bench for the channel 0 input-select block
module test_adc_input_mux_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr_strobe = 1'b0;
  logic        rd_strobe = 1'b0;
  logic [31:0] rdata;
  logic        sample_start;
  logic [17:0] pos_lines;
  logic        neg_analog_1;
  logic        neg_low_ref;
  logic        sample_is_b;
  int          num_errors = 0;
  int          check_count = 0;
  logic [31:0] rv;

  // 100 ns period
  always #50 clk = ~clk;

  adc_input_mux_select dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .sample_start(sample_start),
    .pos_lines(pos_lines), .neg_analog_1(neg_analog_1), .neg_low_ref(neg_low_ref),
    .sample_is_b(sample_is_b));
  adc_seq_model seq (.clk(clk), .sample_start(sample_start));

  task summarize();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle strobes, changed just after the edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  // expected positive line for a code outside scan and calibration
  function automatic logic [17:0] exp_line(input logic [3:0] c);
    if (c <= 4'hC) return 18'h0_0001 << c;
    if (c == 4'hD) return 18'h0_0001 << 13;
    if (c == 4'hE) return 18'h0_0001 << 15;
    return 18'h0_0000;
  endfunction : exp_line

  task look(input logic [17:0] l, input logic n1, input logic b);
    chk(32'(pos_lines), 32'(l));
    chk(32'(neg_analog_1), 32'(n1));
    chk(32'(neg_low_ref), 32'(!n1));
    chk(32'(sample_is_b), 32'(b));
  endtask : look

  task t_reset();
    rd(adc_mux_pkg::OFF_INPUT_SELECT);
    chk(rv, 32'h0000_0000);
    rd(adc_mux_pkg::OFF_SCAN_SELECT);
    chk(rv, 32'h0000_0000);
    look(18'h0_0001, 1'b0, 1'b0);
  endtask : t_reset

  task t_regs();
    wr(adc_mux_pkg::OFF_INPUT_SELECT, 32'hFFFF_FFFF);
    rd(adc_mux_pkg::OFF_INPUT_SELECT);
    chk(rv, 32'h8F8F_0000);
    wr(adc_mux_pkg::OFF_SCAN_SELECT, 32'hFFFF_FFFF);
    rd(adc_mux_pkg::OFF_SCAN_SELECT);
    chk(rv, 32'h0000_FFFF);
    wr(adc_mux_pkg::OFF_SCAN_SELECT, 32'h0000_0000);
    rd(adc_mux_pkg::OFF_SCAN_SELECT);
    chk(rv, 32'h0000_0000);
    wr(adc_mux_pkg::OFF_CONTROL, 32'hFFFF_FFFF);
    rd(adc_mux_pkg::OFF_CONTROL);
    chk(rv, 32'h0000_0007);
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk(rv, 32'h0000_0000); // unmapped place reads zero
  endtask : t_regs

  // every Sample A code, negative select following the low code bit
  task t_codes();
    for (int c = 0; c < 16; c++) begin
      wr(adc_mux_pkg::OFF_INPUT_SELECT, {8'h00, c[0], 3'h0, c[3:0], 16'h0000});
      seq.pulse();
      look(exp_line(c[3:0]), c[0], 1'b0);
    end
  endtask : t_codes

  // B holds code 5 with analog 1 negative, A holds code 2 with low reference
  task t_alt();
    wr(adc_mux_pkg::OFF_INPUT_SELECT, 32'h8502_0000);
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      seq.pulse();
      look(i[0] ? exp_line(4'h5) : exp_line(4'h2), i[0], i[0]);
      rd(adc_mux_pkg::OFF_STATUS);
      chk(rv, 32'(i[0]));
    end
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      seq.pulse();
      look(exp_line(4'h2), 1'b0, 1'b0);
    end
  endtask : t_alt

  // mask picks input 3 plus unit, reference and ground, then wraps
  task automatic t_scan();
    int idx [5] = '{3, 14, 15, 16, 3};
    // empty mask converts the low reference, and is not reported as calibration
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0002);
    seq.pulse();
    look(18'h2_0000, 1'b0, 1'b0);
    rd(adc_mux_pkg::OFF_STATUS);
    chk(rv, 32'h0000_0002);
    wr(adc_mux_pkg::OFF_SCAN_SELECT, 32'h0000_E008);
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0002);
    foreach (idx[i]) begin
      seq.pulse();
      look(18'h0_0001 << idx[i], 1'b0, 1'b0);
      rd(adc_mux_pkg::OFF_STATUS);
      chk(rv, {24'h00_0000, 4'(idx[i] > 12 ? idx[i] - 1 : idx[i]), 4'h2});
    end
  endtask : t_scan

  // calibration wins over scan; a later write waits for the next sample
  task t_cal_mid();
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0006);
    seq.pulse();
    look(18'h2_0000, 1'b0, 1'b0);
    rd(adc_mux_pkg::OFF_STATUS);
    chk(rv & 32'h0000_000F, 32'h0000_0004);
    wr(adc_mux_pkg::OFF_CONTROL, 32'h0000_0000);
    wr(adc_mux_pkg::OFF_INPUT_SELECT, 32'h0007_0000);
    chk(32'(pos_lines), 32'h0002_0000);
    seq.pulse();
    look(exp_line(4'h7), 1'b0, 1'b0);
  endtask : t_cal_mid

  // guard against a hung run
  initial begin
    #1_000_000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_codes();
    t_alt();
    t_scan();
    t_cal_mid();
    summarize();
  end
endmodule : test_adc_input_mux_select
